//--- dv/core_model.sv
`timescale 1ns/1ps
module core_model
  import sram_access_pkg::*;
(
  input wire logic clk,
  input wire logic [ADDR_W-1:0] rdAddr,
  output logic [DATA_W-1:0] rdData,
  input wire logic wrValid,
  input wire wrEntry_t wrEntry,
  output logic wrReady,
  input wire logic stall
);
  // Small array: only the low six address bits are decoded
  logic [DATA_W-1:0] mem [64];

  // Read answers in the same cycle, as the controller expects
  assign rdData = mem[rdAddr[5:0]];
  // Stall holds off entries so the write buffer really backs up
  assign wrReady = !stall;

  ////////////////////////////////////////
  // Lane-wise store; no write pulse comes from outside
  always @(posedge clk) begin
    if (wrValid && wrReady) begin
      for (int i = 0; i < LANES; i++) begin
        if (wrEntry.lanes[i]) begin
          mem[wrEntry.addr[5:0]][i*LANE_W +: LANE_W] <= wrEntry.data[i*LANE_W +: LANE_W];
        end
      end
    end
  end
endmodule

//--- dv/pipelined_burst_sram_access_bench.sv
`timescale 1ns/1ps
module pipelined_burst_sram_access_bench
  import sram_access_pkg::*;
;
  logic clk = 1'h0;
  logic rst_n = 1'h0;
  logic [ADDR_W-1:0] addr = 19'h00000;
  logic procStb_n = 1'h1;
  logic ctrlStb_n = 1'h1;
  logic advance_n = 1'h1;
  logic glbWr_n = 1'h1;
  logic byteEn_n = 1'h1;
  logic [LANES-1:0] laneSel_n = 4'hF;
  logic sel1_n = 1'h0;
  logic sel2 = 1'h1;
  logic sel3_n = 1'h0;
  logic oe_n = 1'h0;
  logic strap = 1'h0;
  logic stall = 1'h0;
  logic [DATA_W-1:0] din = 36'h000000000;
  logic [DATA_W-1:0] dout;
  logic [DATA_W-1:0] rdData;
  logic [ADDR_W-1:0] rdAddr;
  logic doutEn_n;
  logic wrValid;
  logic wrReady;
  logic bufReady;
  wrEntry_t wrEntry;
  int fails = 0;
  int total_checks = 0;

  sram_access_ctrl sram_access_ctrl_i (
    .clk(clk), .rst_n(rst_n), .address(addr), .processorAddrStrobe_n(procStb_n),
    .controllerAddrStrobe_n(ctrlStb_n), .burstAdvance_n(advance_n), .globalWrite_n(glbWr_n),
    .byteWriteEnable_n(byteEn_n), .byteLaneSelect_n(laneSel_n), .chipSelFirst_n(sel1_n),
    .chipSelSecond(sel2), .chipSelThird_n(sel3_n), .outputEnable_n(oe_n),
    .burstOrderStrap(strap), .dataIn(din), .dataOut_r(dout), .dataOutEn_n_r(doutEn_n),
    .coreRdAddr_r(rdAddr), .coreRdData(rdData), .coreWrValid_r(wrValid),
    .coreWrEntry_r(wrEntry), .coreWrReady(wrReady), .bufReady_r(bufReady)
  );
  core_model core_model_i (
    .clk(clk), .rdAddr(rdAddr), .rdData(rdData), .wrValid(wrValid), .wrEntry(wrEntry),
    .wrReady(wrReady), .stall(stall)
  );

  // 250 MHz clock
  always #2 clk = ~clk;

  ////////////////////////////////////////
  // Comparisons and the closing report
  task automatic chkData(string what, logic [DATA_W-1:0] exp, logic [DATA_W-1:0] got);
    total_checks++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic chkBit(string what, logic exp, logic got);
    total_checks++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] %s expected %b seen %b", what, exp, got);
    end
  endtask
  task automatic chkEntry(string what, wrEntry_t exp, wrEntry_t got);
    total_checks++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic conclude;
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  ////////////////////////////////////////
  // Bus steps; inputs move only at the falling edge
  task automatic tick;
    @(posedge clk);
    @(negedge clk);
  endtask
  // Op tasks leave their controls up; callers idle explicitly, so no signal moves twice
  task automatic idle;
    procStb_n = 1'h1;
    ctrlStb_n = 1'h1;
    advance_n = 1'h1;
    glbWr_n = 1'h1;
    byteEn_n = 1'h1;
    laneSel_n = 4'hF;
    sel1_n = 1'h0;
    sel2 = 1'h1;
  endtask
  task automatic waitValid(logic want);
    for (int n = 0; wrValid !== want; n++) begin
      if (n == 40) begin
        fails++;
        conclude;
      end
      tick;
    end
  endtask
  // Writes are not forwarded to reads, so let the buffer empty first
  task automatic drain;
    idle;
    repeat (3) tick;
    waitValid(1'h0);
    tick;
  endtask
  task automatic cwr(logic [ADDR_W-1:0] a, logic [DATA_W-1:0] d, logic g, logic b,
                     logic [LANES-1:0] s);
    ctrlStb_n = 1'h0;
    addr = a;
    din = d;
    glbWr_n = g;
    byteEn_n = b;
    laneSel_n = s;
    tick;
  endtask
  // Both strobes low: a controller write here would store the inverted data at once
  task automatic pwr(logic [ADDR_W-1:0] a, logic [DATA_W-1:0] d, logic g, logic b,
                     logic [LANES-1:0] s);
    procStb_n = 1'h0;
    ctrlStb_n = 1'h0;
    addr = a;
    din = ~d;
    glbWr_n = 1'h0;
    tick;
    procStb_n = 1'h1;
    ctrlStb_n = 1'h1;
    advance_n = 1'h0;
    din = d;
    glbWr_n = g;
    byteEn_n = b;
    laneSel_n = s;
    tick;
  endtask
  task automatic crd(logic [ADDR_W-1:0] a);
    ctrlStb_n = 1'h0;
    addr = a;
    tick;
  endtask
  task automatic rdChk(logic [ADDR_W-1:0] a, logic [DATA_W-1:0] exp);
    crd(a);
    idle;
    tick;
    chkData("read data", exp, dout);
    chkBit("read drive enable", 1'h0, doutEn_n);
  endtask
  function automatic logic [DATA_W-1:0] merge(logic [DATA_W-1:0] o, logic [DATA_W-1:0] n,
                                               logic [LANES-1:0] m);
    merge = o;
    for (int i = 0; i < LANES; i++) begin
      if (m[i]) begin
        merge[i*LANE_W +: LANE_W] = n[i*LANE_W +: LANE_W];
      end
    end
  endfunction
  function automatic logic [DATA_W-1:0] pat(int i);
    pat = {32'hABC00000, i[3:0]};
  endfunction

  ////////////////////////////////////////
  // Scenarios
  task automatic tWrite;
    cwr(19'h00010, 36'h123456789, 1'h0, 1'h0, 4'hE);
    drain;
    rdChk(19'h00010, 36'h123456789);
    cwr(19'h00011, 36'h9ABCDEF01, 1'h0, 1'h1, 4'hF);
    chkBit("drive enable on write", 1'h1, doutEn_n);
    drain;
    rdChk(19'h00011, 36'h9ABCDEF01);
    $display("write test done");
  endtask
  task automatic tByte;
    logic [DATA_W-1:0] v;
    v = merge(36'h123456789, 36'h0F0F0F0F0, 4'h5);
    cwr(19'h00010, 36'h0F0F0F0F0, 1'h1, 1'h0, 4'hA);
    drain;
    rdChk(19'h00010, v);
    pwr(19'h00010, 36'h555555555, 1'h1, 1'h0, 4'h7);
    idle;
    waitValid(1'h1);
    chkEntry("write entry", '{19'h00010, 36'h555555555, 4'h8}, wrEntry);
    drain;
    rdChk(19'h00010, merge(v, 36'h555555555, 4'h8));
    pwr(19'h00011, 36'h0AAAAAAAA, 1'h0, 1'h1, 4'hF);
    drain;
    rdChk(19'h00011, 36'h0AAAAAAAA);
    $display("byte test done");
  endtask
  task automatic tBurst;
    logic [1:0] k;
    logic [1:0] p;
    for (int i = 0; i < 4; i++) begin
      cwr(19'h00020 + 19'(i), pat(i), 1'h0, 1'h1, 4'hF);
    end
    drain;
    for (int m = 0; m < 2; m++) begin
      // The strap may only move while the block is held in reset
      rst_n = 1'h0;
      strap = m[0];
      repeat (2) tick;
      rst_n = 1'h1;
      repeat (3) tick;
      crd(19'h00021);
      chkBit("enable leaving reset", 1'h1, doutEn_n);
      ctrlStb_n = 1'h1;
      advance_n = 1'h0;
      // Data trails the position by one edge; the last pass holds
      for (int n = 0; n < 5; n++) begin
        if (n == 3) begin
          advance_n = 1'h1;
        end
        tick;
        k = (n > 3) ? 2'h3 : n[1:0];
        p = strap ? (2'h1 ^ k) : (2'h1 + k);
        chkData("burst data", pat(p), dout);
      end
    end
    crd(19'h00023);
    crd(19'h00020);
    chkData("back to back first", pat(3), dout);
    ctrlStb_n = 1'h1;
    tick;
    chkData("back to back second", pat(0), dout);
    $display("burst test done");
  endtask
  task automatic tDesel;
    rdChk(19'h00022, pat(2));
    procStb_n = 1'h0;
    sel1_n = 1'h1;
    addr = 19'h00023;
    tick;
    procStb_n = 1'h1;
    sel1_n = 1'h0;
    tick;
    chkData("ignored strobe", pat(2), dout);
    chkBit("drive after ignored strobe", 1'h0, doutEn_n);
    ctrlStb_n = 1'h0;
    sel2 = 1'h0;
    tick;
    chkBit("enable at deselect", 1'h0, doutEn_n);
    ctrlStb_n = 1'h1;
    sel2 = 1'h1;
    tick;
    chkBit("enable one edge later", 1'h1, doutEn_n);
    crd(19'h00021);
    chkBit("enable after reselect", 1'h1, doutEn_n);
    idle;
    tick;
    chkData("read after deselect", pat(1), dout);
    tick;
    chkBit("enable in later cycle", 1'h0, doutEn_n);
    // A read started by the processor strobe alone
    procStb_n = 1'h0;
    addr = 19'h00023;
    tick;
    idle;
    tick;
    chkData("processor read data", pat(3), dout);
    chkBit("processor read enable", 1'h0, doutEn_n);
    $display("deselect test done");
  endtask
  // Seven writes against a stalled core overrun four slots plus the output register
  task automatic tFifo;
    stall = 1'h1;
    oe_n = 1'h1;
    for (int i = 0; i < 7; i++) begin
      cwr(19'h00030 + 19'(i), pat(i + 8), 1'h0, 1'h1, 4'hF);
    end
    idle;
    repeat (3) tick;
    chkBit("ready when full", 1'h0, bufReady);
    chkBit("enable with oe high", 1'h1, doutEn_n);
    chkEntry("oldest entry held", '{19'h00030, pat(8), 4'hF}, wrEntry);
    stall = 1'h0;
    drain;
    chkBit("ready after drain", 1'h1, bufReady);
    oe_n = 1'h0;
    repeat (3) tick;
    rdChk(19'h00030, pat(8));
    $display("buffer test done");
  endtask

  initial begin
    repeat (5) @(negedge clk);
    rst_n = 1'h1;
    repeat (3) tick;
    tWrite;
    tByte;
    tBurst;
    tDesel;
    tFifo;
    conclude;
  end
endmodule

//--- include/sram_access_pkg.sv
package sram_access_pkg;

  // Array geometry: four lanes of eight data bits plus one parity bit
  localparam int ADDR_W = 19;
  localparam int LANES = 4;
  localparam int LANE_W = 9;
  localparam int DATA_W = LANES * LANE_W;
  localparam int CNT_W = 2;

  // Write buffer in front of the core
  localparam int FIFO_DEPTH = 4;

  // Lane masks and burst constants
  localparam logic [LANES-1:0] LANE_ALL = 4'hF;
  localparam logic [LANES-1:0] LANE_NONE = 4'h0;
  localparam logic [CNT_W-1:0] STEP_ZERO = 2'h0;
  localparam logic [CNT_W-1:0] STEP_ONE = 2'h1;

  // Strap level that selects the linear order
  localparam logic ORDER_LINEAR = 1'h0;

  // Active-low output enable level meaning drivers off
  localparam logic OEN_OFF = 1'h1;

  typedef enum logic [1:0] {
    ACC_DESEL,
    ACC_PROC_FIRST,
    ACC_READ,
    ACC_WRITE
  } accState_t;

  // One write handed to the core
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
    logic [LANES-1:0] lanes;
  } wrEntry_t;

  localparam int ENTRY_W = $bits(wrEntry_t);

endpackage

//--- rtl/sram_access_ctrl.sv
`timescale 1ns/1ps
// What this block does
// - Burst order is linear with the strap low, interleaved with it high.
// - All synchronous inputs and all read data pass rising-edge registers.
// - A two-bit wrapping counter takes the low start address and forms the rest.
// - The burst position moves only when burst advance asks for it.
// - Global write stores all four lanes whatever the byte controls say.
// - Otherwise only lanes selected under byte-write enable are stored.
// - The processor strobe is ignored while the first chip select is high.
// - A strobe with selects active and no write controls starts a read.
// - Read data leave the output register one edge after the address, gated by enable.
// - The first cycle after a deselected state keeps the outputs off.
// - Single reads may follow each other on every cycle.
// - After a registered deselect the outputs drive one more cycle, then turn off.
// - A processor-strobe access loads the address and ignores write and advance.
// - A processor-strobe write samples controls and data at its second edge.
// - With global write high there, byte enable and lane selects pick lanes.
// - The write is timed inside from the edge that registers it.
// - Any detected write turns the data drivers off regardless of enable.
// - Selected means first low, second high, third low, sampled on loads only.
// - With both strobes low and the first chip select low, only the processor strobe is acted on.
// - Interleaved steps XOR the count into the start; linear adds one.
// - Burst advance low at an edge moves the counter for reads and writes.
module sram_access_ctrl
  import sram_access_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [ADDR_W-1:0] address,
  input wire logic processorAddrStrobe_n,
  input wire logic controllerAddrStrobe_n,
  input wire logic burstAdvance_n,
  input wire logic globalWrite_n,
  input wire logic byteWriteEnable_n,
  input wire logic [LANES-1:0] byteLaneSelect_n,
  input wire logic chipSelFirst_n,
  input wire logic chipSelSecond,
  input wire logic chipSelThird_n,
  input wire logic outputEnable_n,
  input wire logic burstOrderStrap,
  input wire logic [DATA_W-1:0] dataIn,
  output logic [DATA_W-1:0] dataOut_r,
  output logic dataOutEn_n_r,
  output logic [ADDR_W-1:0] coreRdAddr_r,
  input wire logic [DATA_W-1:0] coreRdData,
  output logic coreWrValid_r,
  output wrEntry_t coreWrEntry_r,
  input wire logic coreWrReady,
  output logic bufReady_r
);

  typedef struct packed {
    accState_t acc;
    logic [ADDR_W-1:0] coreAddr;
    logic [CNT_W-1:0] start;
    logic [CNT_W-1:0] step;
    logic readIssue;
    logic [DATA_W-1:0] dataOut;
    logic dataOutEn_n;
    wrEntry_t push;
    logic pushValid;
    logic oeSync1;
    logic oeSync2;
    logic modeSync1;
    logic modeSync2;
    logic bufReady;
  } state_t;

  localparam state_t ST_RESET = '{
    acc: ACC_DESEL,
    dataOutEn_n: OEN_OFF,
    oeSync1: OEN_OFF,
    oeSync2: OEN_OFF,
    default: '0
  };

  state_t st_r;
  state_t st_nxt;

  logic selected;
  logic adspTake;
  logic adscTake;
  logic loadNow;
  logic loadSel;
  logic deselNow;
  logic maskFirst;
  logic writeCtl;
  logic writeNow;
  logic advNow;
  logic drive;
  logic fifoInReady;
  logic [CNT_W-1:0] stepInc;
  logic [LANES-1:0] laneNow;

  ////////////////////////////////////////////////////////////////////////////
  // Decoders shared by the load path and the burst path

  // Position inside the four-word burst for a given step count
  function automatic logic [CNT_W-1:0] burstPos(
    input logic [CNT_W-1:0] startPos,
    input logic [CNT_W-1:0] stepCnt,
    input logic interleaved
  );
    if (interleaved) begin
      burstPos = startPos ^ stepCnt;
    end else begin
      burstPos = CNT_W'(startPos + stepCnt);
    end
  endfunction

  // Lanes that a write stores
  function automatic logic [LANES-1:0] laneMask(
    input logic gwN,
    input logic bweN,
    input logic [LANES-1:0] selN
  );
    if (!gwN) begin
      laneMask = LANE_ALL;
    end else if (!bweN) begin
      laneMask = ~selN;
    end else begin
      laneMask = LANE_NONE;
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Strobe qualification, sampled at every edge
  assign selected = !chipSelFirst_n && chipSelSecond && !chipSelThird_n;
  assign adspTake = !processorAddrStrobe_n && !chipSelFirst_n;
  assign adscTake = !controllerAddrStrobe_n && !adspTake;
  assign loadNow = adspTake || adscTake;
  assign loadSel = loadNow && selected;
  assign deselNow = loadNow && !selected;
  assign maskFirst = loadSel && (st_r.acc == ACC_DESEL);
  assign writeCtl = !globalWrite_n || !byteWriteEnable_n;
  assign laneNow = laneMask(globalWrite_n, byteWriteEnable_n, byteLaneSelect_n);
  assign stepInc = CNT_W'(st_r.step + STEP_ONE);

  ////////////////////////////////////////////////////////////////////////////
  // Access sequencing; a new strobe always wins over a running burst
  always_comb begin
    st_nxt = st_r;
    writeNow = 1'h0;
    advNow = 1'h0;
    drive = 1'h0;
    // Output enable and strap come from pins, so they get two flops
    st_nxt.oeSync1 = outputEnable_n;
    st_nxt.oeSync2 = st_r.oeSync1;
    st_nxt.modeSync1 = burstOrderStrap;
    st_nxt.modeSync2 = st_r.modeSync1;
    st_nxt.bufReady = fifoInReady;
    st_nxt.pushValid = 1'h0;
    if (loadNow) begin
      if (!selected) begin
        st_nxt.acc = ACC_DESEL;
        st_nxt.readIssue = 1'h0;
      end else begin
        st_nxt.coreAddr = address;
        st_nxt.start = address[CNT_W-1:0];
        st_nxt.step = STEP_ZERO;
        if (adspTake) begin
          // First cycle reads; write controls wait one cycle, advance waits two
          st_nxt.acc = ACC_PROC_FIRST;
          st_nxt.readIssue = 1'h1;
        end else if (writeCtl) begin
          st_nxt.acc = ACC_WRITE;
          st_nxt.readIssue = 1'h0;
          writeNow = 1'h1;
        end else begin
          st_nxt.acc = ACC_READ;
          st_nxt.readIssue = 1'h1;
        end
      end
    end else begin
      case (st_r.acc)
        ACC_DESEL: begin
          st_nxt.readIssue = 1'h0;
        end
        ACC_PROC_FIRST: begin
          // Second edge completes the first word at the loaded address
          if (writeCtl) begin
            st_nxt.acc = ACC_WRITE;
            st_nxt.readIssue = 1'h0;
            writeNow = 1'h1;
          end else begin
            st_nxt.acc = ACC_READ;
            st_nxt.readIssue = 1'h1;
          end
        end
        ACC_READ, ACC_WRITE: begin
          if (!burstAdvance_n) begin
            advNow = 1'h1;
            st_nxt.step = stepInc;
            st_nxt.coreAddr[CNT_W-1:0] = burstPos(st_r.start, stepInc, st_r.modeSync2);
          end
          if (writeCtl) begin
            st_nxt.acc = ACC_WRITE;
            st_nxt.readIssue = 1'h0;
            writeNow = 1'h1;
          end else begin
            st_nxt.acc = ACC_READ;
            st_nxt.readIssue = 1'h1;
          end
        end
        default: begin
          st_nxt.acc = ACC_DESEL;
          st_nxt.readIssue = 1'h0;
        end
      endcase
    end
    // Self-timed write: address, data and lanes captured on the same edge
    if (writeNow) begin
      st_nxt.push.addr = st_nxt.coreAddr;
      st_nxt.push.data = dataIn;
      st_nxt.push.lanes = laneNow;
      st_nxt.pushValid = 1'h1;
    end
    // Output stage; a deselect leaves the last read driving one more cycle
    drive = st_r.readIssue && !st_r.oeSync2 && !writeNow && !maskFirst;
    st_nxt.dataOutEn_n = !drive;
    if (st_r.readIssue) begin
      st_nxt.dataOut = coreRdData;
    end
  end

  // All state in one register; inputs land here first
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_r <= ST_RESET;
    end else begin
      st_r <= st_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Write buffer; an entry offered while it is full is lost, so the
  // master must watch bufReady_r before starting writes
  sync_fifo #(
    .WIDTH(ENTRY_W),
    .DEPTH(FIFO_DEPTH)
  ) sync_fifo_i (
    .clk(clk),
    .rst_n(rst_n),
    .inValid(st_r.pushValid),
    .inReady(fifoInReady),
    .inData(st_r.push),
    .outValid_r(coreWrValid_r),
    .outReady(coreWrReady),
    .outData_r(coreWrEntry_r)
  );

  // Port drivers, all straight from the state register
  assign dataOut_r = st_r.dataOut;
  assign dataOutEn_n_r = st_r.dataOutEn_n;
  assign coreRdAddr_r = st_r.coreAddr;
  assign bufReady_r = st_r.bufReady;

  ////////////////////////////////////////////////////////////////////////////
  // Checks on the access sequencing
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  sequence readLoad;
    loadSel && !adspTake && !writeCtl;
  endsequence

  sequence procStart;
    adspTake && selected;
  endsequence

  sequence procSecondWrite;
    procStart ##1 (!loadNow && writeCtl);
  endsequence

  logic [CNT_W-1:0] linPos;
  logic [CNT_W-1:0] interPos;
  assign linPos = CNT_W'(st_r.start + stepInc);
  assign interPos = st_r.start ^ stepInc;

  a_desel_turn_off: assert property (deselNow |-> ##2 dataOutEn_n_r)
    else $error("outputs still driven two edges after deselect");
  a_desel_keeps_drive: assert property (
    deselNow && st_r.readIssue && !st_r.oeSync2 |=> !dataOutEn_n_r)
    else $error("outputs dropped at the deselect edge");
  a_write_tristate: assert property (writeNow |=> dataOutEn_n_r)
    else $error("drivers on during a write");
  a_read_data_out: assert property (
    readLoad ##1 (!st_r.oeSync2 && !writeNow) |=>
      !dataOutEn_n_r && dataOut_r == $past(coreRdData))
    else $error("read data not presented one edge after address");
  a_first_masked: assert property (maskFirst |=> dataOutEn_n_r)
    else $error("outputs on in first cycle after deselected state");
  a_proc_first_nowrite: assert property (procStart |=> !st_r.pushValid)
    else $error("write taken in first processor-strobe cycle");
  a_proc_second_write: assert property (
    procSecondWrite |=> st_r.pushValid && st_r.push.addr == $past(st_r.coreAddr)
      && st_r.push.lanes == $past(laneNow))
    else $error("processor-strobe write not stored at second edge");
  a_global_all_lanes: assert property (
    writeNow && !globalWrite_n |=> st_r.push.lanes == LANE_ALL)
    else $error("global write did not select all lanes");
  a_byte_lanes: assert property (
    writeNow && globalWrite_n |=> st_r.push.lanes == ~$past(byteLaneSelect_n))
    else $error("byte write lanes wrong");
  a_load_address: assert property (loadSel |=> coreRdAddr_r == $past(address))
    else $error("address not loaded on strobe");
  a_burst_linear: assert property (
    advNow && st_r.modeSync2 == ORDER_LINEAR |=>
      coreRdAddr_r[CNT_W-1:0] == $past(linPos))
    else $error("linear burst step wrong");
  a_burst_interleave: assert property (
    advNow && st_r.modeSync2 != ORDER_LINEAR |=>
      coreRdAddr_r[CNT_W-1:0] == $past(interPos))
    else $error("interleaved burst step wrong");
  a_hold_address: assert property (
    !loadNow && burstAdvance_n |=> $stable(coreRdAddr_r) && $stable(st_r.step))
    else $error("address moved without strobe or advance");

  // Strobe arbitration: with both strobes low and the first chip select low the controller strobe is dropped
  sequence bothStrobes;
    !processorAddrStrobe_n && !controllerAddrStrobe_n && !chipSelFirst_n;
  endsequence

  a_both_proc_only: assert property (
    bothStrobes ##0 selected |=> st_r.acc == ACC_PROC_FIRST && !st_r.pushValid)
    else $error("controller strobe acted on beside processor strobe");
  // An ignored processor strobe must not reload the burst start or the address
  a_proc_ignored: assert property (
    !processorAddrStrobe_n && chipSelFirst_n && controllerAddrStrobe_n |=>
      $stable(st_r.start) && $stable(st_r.coreAddr[ADDR_W-1:CNT_W]))
    else $error("processor strobe taken with first chip select high");
  // Second edge of a processor-strobe access finishes the loaded word, no step
  a_proc_second_hold: assert property (
    procStart ##1 !loadNow |=> $stable(st_r.step) && $stable(coreRdAddr_r))
    else $error("burst advanced at second processor-strobe edge");
  // Advance low inside a running access moves the step by one and wraps
  a_step_advance: assert property (
    !loadNow && !burstAdvance_n && (st_r.acc == ACC_READ || st_r.acc == ACC_WRITE) |=>
      st_r.step == CNT_W'($past(st_r.step) + STEP_ONE))
    else $error("burst counter did not move on advance");
  // A load without full chip selection parks the access and stops reads
  a_desel_state: assert property (deselNow |=> st_r.acc == ACC_DESEL && !st_r.readIssue)
    else $error("deselect did not park the access");

endmodule

//--- rtl/sync_fifo.sv
`timescale 1ns/1ps
module sync_fifo
  import sram_access_pkg::*;
#(
  parameter int WIDTH = ENTRY_W,
  parameter int DEPTH = FIFO_DEPTH
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic inValid,
  output logic inReady,
  input wire logic [WIDTH-1:0] inData,
  output logic outValid_r,
  input wire logic outReady,
  output logic [WIDTH-1:0] outData_r
);

  localparam int PTR_W = $clog2(DEPTH);
  localparam int CW = PTR_W + 1;
  localparam logic [CW-1:0] FULL_COUNT = CW'(DEPTH);
  localparam logic [PTR_W-1:0] PTR_ONE = PTR_W'(1);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [PTR_W-1:0] wrPtr;
    logic [PTR_W-1:0] rdPtr;
    logic [CW-1:0] count;
    logic outValid;
    logic [WIDTH-1:0] outData;
  } fifoState_t;

  fifoState_t s_r;
  fifoState_t s_nxt;
  logic take;
  logic pop;

  // Full is honest: the storage alone decides, the output register adds one slot
  assign inReady = (s_r.count != FULL_COUNT);

  ////////////////////////////////////////////////////////////////////////////
  // Next state: output register refills whenever it is empty or drained
  always_comb begin
    s_nxt = s_r;
    take = inValid && inReady;
    pop = (s_r.count != '0) && (!s_r.outValid || outReady);
    if (s_r.outValid && outReady) begin
      s_nxt.outValid = 1'h0;
    end
    if (pop) begin
      s_nxt.outData = s_r.mem[s_r.rdPtr];
      s_nxt.outValid = 1'h1;
      s_nxt.rdPtr = s_r.rdPtr + PTR_ONE;
    end
    if (take) begin
      s_nxt.mem[s_r.wrPtr] = inData;
      s_nxt.wrPtr = s_r.wrPtr + PTR_ONE;
    end
    s_nxt.count = s_r.count + CW'(take) - CW'(pop);
  end

  // State register
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign outValid_r = s_r.outValid;
  assign outData_r = s_r.outData;

endmodule
